// ### hdl/pcsf_map.svh
`ifndef PCSF_MAP_SVH
`define PCSF_MAP_SVH

// register offsets on the channel map
`define PCSF_ADDR_CFG_LOW 8'h0e
`define PCSF_ADDR_CFG_HIGH 8'h0f
`define PCSF_ADDR_SEL0 8'h12
`define PCSF_ADDR_SEL1 8'h13
`define PCSF_ADDR_SEL2 8'h14
`define PCSF_ADDR_SEL3 8'h15
`define PCSF_STATUS_BASE 8'h40

// reset value of every config register
`define PCSF_RST_VAL 8'h00

// field positions
`define PCSF_CODE_HI_MSB 7
`define PCSF_CODE_HI_LSB 4
`define PCSF_CODE_LO_MSB 3
`define PCSF_CODE_LO_LSB 0
`define PCSF_SEL_REG_MSB 7
`define PCSF_SEL_REG_LSB 3
`define PCSF_SEL_BIT_MSB 2
`define PCSF_SEL_BIT_LSB 0

// status window: 32 registers of 8 bits
`define PCSF_STATUS_BITS 256
`define PCSF_LEVEL_IDX 5'h0e
`define PCSF_LOS_MASK 256'h0001_0101_0000_0000_0000_0000
`define PCSF_IMPL_MASK {256{1'b1}}

`define PCSF_NPINS 4

`endif

// ### hdl/pcsf_pin.sv
`include "pcsf_map.svh"

module pcsf_pin #(
  parameter logic [`PCSF_STATUS_BITS-1:0] FOLLOW_MASK = `PCSF_IMPL_MASK
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chan_rst,
  input wire logic [3:0] code,
  input wire pcsf_pkg::pcsf_sel_t sel,
  input wire logic [`PCSF_STATUS_BITS-1:0] status_bits,
  input wire logic level,
  output pcsf_pkg::pcsf_drive_t drive,
  output logic event_pulse
);

  logic [7:0] flat_idx;
  logic followable;
  logic fbit;
  logic prev_r;
  pcsf_pkg::pcsf_drive_t drive_nxt;

  assign flat_idx = {sel.reg_idx, sel.bit_idx};
  assign followable = FOLLOW_MASK[flat_idx];
  assign fbit = followable & status_bits[flat_idx];

  // pin function decode
  always_comb
  begin
    drive_nxt = '{out: 1'b0, oe: 1'b0};
    unique case (pcsf_pkg::pcsf_func_t'(code))
      pcsf_pkg::PCSF_IN, pcsf_pkg::PCSF_IN_INV:
        drive_nxt = '{out: 1'b0, oe: 1'b0};
      pcsf_pkg::PCSF_OUT_LOW:
        drive_nxt = '{out: 1'b0, oe: 1'b1};
      pcsf_pkg::PCSF_OUT_HIGH:
        drive_nxt = '{out: 1'b1, oe: 1'b1};
      pcsf_pkg::PCSF_ST_PLAIN:
        drive_nxt = '{out: fbit, oe: 1'b1};
      pcsf_pkg::PCSF_ST_INV:
        drive_nxt = '{out: ~fbit, oe: 1'b1};
      pcsf_pkg::PCSF_ST_LOW_ON_0:
        drive_nxt = '{out: 1'b0, oe: ~fbit};
      pcsf_pkg::PCSF_ST_LOW_ON_1:
        drive_nxt = '{out: 1'b0, oe: fbit};
      default:
        drive_nxt = '{out: 1'b0, oe: 1'b0};
    endcase
    if (code[3:2] == 2'b01 && !followable)
    begin
      drive_nxt = '{out: 1'b0, oe: 1'b1};
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive <= '{out: 1'b0, oe: 1'b0};
    end
    else if (chan_rst)
    begin
      drive <= '{out: 1'b0, oe: 1'b0};
    end
    else
    begin
      drive <= drive_nxt;
    end
  end

  // edge event: rising for plain input, falling for inverted
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_r <= 1'b0;
      event_pulse <= 1'b0;
    end
    else
    begin
      prev_r <= level;
      if (code == 4'h1)
      begin
        event_pulse <= prev_r & ~level;
      end
      else
      begin
        event_pulse <= ~prev_r & level;
      end
    end
  end

endmodule

// ### hdl/pcsf_pkg.sv
package pcsf_pkg;

  typedef enum logic [3:0] {
    PCSF_IN = 4'h0,
    PCSF_IN_INV = 4'h1,
    PCSF_OUT_LOW = 4'h2,
    PCSF_OUT_HIGH = 4'h3,
    PCSF_ST_PLAIN = 4'h4,
    PCSF_ST_INV = 4'h5,
    PCSF_ST_LOW_ON_0 = 4'h6,
    PCSF_ST_LOW_ON_1 = 4'h7
  } pcsf_func_t;

  typedef struct packed {
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;
  } pcsf_sel_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pcsf_drive_t;

endpackage

// ### hdl/pcsf_top.sv
`include "pcsf_map.svh"

module pcsf_top #(
  parameter int NPINS = `PCSF_NPINS,
  parameter logic [`PCSF_STATUS_BITS-1:0] IMPL_MASK = `PCSF_IMPL_MASK,
  parameter logic [`PCSF_STATUS_BITS-1:0] LOS_MASK = `PCSF_LOS_MASK,
  parameter logic [4:0] LEVEL_IDX = `PCSF_LEVEL_IDX
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chan_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  input wire logic [`PCSF_STATUS_BITS-1:0] status_bits,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_level,
  output logic [NPINS-1:0] pin_sense,
  output logic [NPINS-1:0] pin_event
);

  ////////////////////////////////////////////////////////////////////////////
  // followable mask: implemented bits minus excluded sources

  localparam logic [`PCSF_STATUS_BITS-1:0] LEVEL_MASK =
    {{(`PCSF_STATUS_BITS-8){1'b0}}, 8'hff} << {LEVEL_IDX, 3'h0};
  localparam logic [`PCSF_STATUS_BITS-1:0] FOLLOW_MASK =
    IMPL_MASK & ~LOS_MASK & ~LEVEL_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // config registers

  logic [7:0] cfg_low_r;
  logic [7:0] cfg_high_r;
  pcsf_pkg::pcsf_sel_t sel_r [NPINS];
  logic [3:0] code [NPINS];

  function automatic logic sel_hit(input logic [7:0] addr);
    return addr >= `PCSF_ADDR_SEL0 && addr <= `PCSF_ADDR_SEL3;
  endfunction

  // status-select slot from its address
  function automatic logic [1:0] sel_idx(input logic [7:0] addr);
    return 2'(addr - `PCSF_ADDR_SEL0);
  endfunction

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_low_r <= `PCSF_RST_VAL;
      cfg_high_r <= `PCSF_RST_VAL;
    end
    else if (chan_rst)
    begin
      cfg_low_r <= `PCSF_RST_VAL;
      cfg_high_r <= `PCSF_RST_VAL;
    end
    else if (reg_wr_en)
    begin
      if (reg_addr == `PCSF_ADDR_CFG_LOW)
      begin
        cfg_low_r <= reg_wr_data;
      end
      if (reg_addr == `PCSF_ADDR_CFG_HIGH)
      begin
        cfg_high_r <= reg_wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        sel_r[i] <= pcsf_pkg::pcsf_sel_t'(`PCSF_RST_VAL);
      end
    end
    else if (chan_rst)
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        sel_r[i] <= pcsf_pkg::pcsf_sel_t'(`PCSF_RST_VAL);
      end
    end
    else if (reg_wr_en && sel_hit(reg_addr))
    begin
      sel_r[sel_idx(reg_addr)] <= pcsf_pkg::pcsf_sel_t'(reg_wr_data);
    end
  end

  assign code[0] = cfg_low_r[`PCSF_CODE_LO_MSB:`PCSF_CODE_LO_LSB];
  assign code[1] = cfg_low_r[`PCSF_CODE_HI_MSB:`PCSF_CODE_HI_LSB];
  assign code[2] = cfg_high_r[`PCSF_CODE_LO_MSB:`PCSF_CODE_LO_LSB];
  assign code[3] = cfg_high_r[`PCSF_CODE_HI_MSB:`PCSF_CODE_HI_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser and sensed level

  logic [NPINS-1:0] sync1_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      pin_level <= '0;
    end
    else
    begin
      sync1_r <= pin_in;
      pin_level <= sync1_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_sense <= '0;
    end
    else
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        pin_sense[i] <= pin_level[i] ^ (code[i] == 4'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rd_data <= 8'h00;
    end
    else if (reg_rd_en)
    begin
      if (reg_addr == `PCSF_ADDR_CFG_LOW)
      begin
        reg_rd_data <= cfg_low_r;
      end
      else if (reg_addr == `PCSF_ADDR_CFG_HIGH)
      begin
        reg_rd_data <= cfg_high_r;
      end
      else if (sel_hit(reg_addr))
      begin
        reg_rd_data <= sel_r[sel_idx(reg_addr)];
      end
      else if (reg_addr == (`PCSF_STATUS_BASE | {3'h0, LEVEL_IDX}))
      begin
        reg_rd_data <= {{(8 - NPINS){1'b0}}, pin_level};
      end
      else
      begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin drive and events

  for (genvar g = 0; g < NPINS; g++)
  begin : g_pin
    pcsf_pkg::pcsf_drive_t drv;

    pcsf_pin #(
      .FOLLOW_MASK(FOLLOW_MASK)
    ) u_pin (
      .core_clk(core_clk),
      .nrst(nrst),
      .chan_rst(chan_rst),
      .code(code[g]),
      .sel(sel_r[g]),
      .status_bits(status_bits),
      .level(pin_level[g]),
      .drive(drv),
      .event_pulse(pin_event[g])
    );

    assign pin_out[g] = drv.out;
    assign pin_oe[g] = drv.oe;
  end

endmodule

// ### sim/pcsf_board.sv
module pcsf_board #(
  parameter int NPINS = 4
) (
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] ext_level,
  output logic [NPINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin falls to the board level
  always_comb
    for (int i = 0; i < NPINS; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
endmodule

// ### sim/pcsf_properties.sv
module pcsf_chk #(
  parameter int NPINS = 4,
  parameter logic [255:0] IMPL_MASK = {256{1'b1}}
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chan_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic [255:0] status_bits,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_level,
  input wire logic [NPINS-1:0] pin_sense,
  input wire logic [NPINS-1:0] pin_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] c_r;
  logic [7:0] s_r;
  logic blk;
  logic fv;
  // pin 0 shadow config and followed value
  assign blk = s_r[7:3] == 5'h0e || s_r == 8'h40 || s_r == 8'h48 || s_r == 8'h50 || !IMPL_MASK[s_r];
  assign fv = (status_bits[s_r] ^ c_r[0]) & !blk;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) c_r <= 4'h0;
    else if (chan_rst) c_r <= 4'h0;
    else if (reg_wr_en && reg_addr == 8'h0e) c_r <= reg_wr_data[3:0];
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) s_r <= 8'h00;
    else if (chan_rst) s_r <= 8'h00;
    else if (reg_wr_en && reg_addr == 8'h12) s_r <= reg_wr_data;
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  no_drive_a: assert property (($past(c_r[3]) || $past(c_r[3:1]) == 3'h0) |-> !pin_oe[0])
    else $error("input code drives pin");
  static_drive_a: assert property ($past(c_r[3:1]) == 3'h1 && !$past(chan_rst)
    |-> pin_oe[0] && pin_out[0] == $past(c_r[0])) else $error("static drive wrong");
  status_follow_a: assert property ($past(c_r[3:1]) == 3'h2 && !$past(chan_rst)
    |-> pin_oe[0] && pin_out[0] == $past(fv)) else $error("status follow wrong");
  open_drain_a: assert property ($past(c_r[3:1]) == 3'h3 && !$past(chan_rst)
    |-> !pin_out[0] && pin_oe[0] == !$past(fv)) else $error("open drain wrong");
  sense_inv_a: assert property (pin_sense[0] == ($past(pin_level[0]) ^ ($past(c_r) == 4'h1)))
    else $error("sense wrong");
  rise_event_a: assert property (c_r == 4'h0 && $rose(pin_level[0]) |=> pin_event[0])
    else $error("rising event missing");
  fall_event_a: assert property (c_r == 4'h1 && $fell(pin_level[0]) |=> pin_event[0])
    else $error("falling event missing");
  level_sync_a: assert property ($past(nrst, 2) && $past(nrst) |-> pin_level == $past(pin_in, 2))
    else $error("level wrong");
  level_read_a: assert property (reg_rd_en && reg_addr == 8'h4e |=> reg_rd_data == {4'h0, $past(pin_level)})
    else $error("level read wrong");
  cover property ($past(c_r[3:1]) == 3'h2 && pin_oe[0]);
  cover property (pin_event[0]);
  cover property (reg_rd_en && reg_addr == 8'h4e);
endmodule
bind pcsf_top pcsf_chk #(.NPINS(NPINS), .IMPL_MASK(IMPL_MASK)) u_chk (.core_clk(core_clk), .nrst(nrst),
  .chan_rst(chan_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .status_bits(status_bits), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level), .pin_sense(pin_sense), .pin_event(pin_event));

// ### sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
  localparam logic [255:0] MASK = ~(256'h1 << 48);
  logic core_clk = 1'b0, nrst = 1'b0, chan_rst = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
  logic [255:0] st = '0;
  logic [3:0] ext = 4'h0, pin_in, pin_out, pin_oe, pin_level, pin_sense, pin_event;
  logic [1:0] d;
  int err_count = 0, cmp_count = 0;
  pcsf_top #(.IMPL_MASK(MASK)) DUT (.core_clk(core_clk), .nrst(nrst), .chan_rst(chan_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .status_bits(st), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level),
    .pin_sense(pin_sense), .pin_event(pin_event));
  pcsf_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  ////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
    `CHK("read", e, reg_rd_data)
  endtask
  task automatic ev(input logic [3:0] v, input logic [3:0] e);
    logic [3:0] seen;
    seen = 4'h0;
    ext <= v;
    repeat (6)
    begin
      @(posedge core_clk);
      seen |= pin_event;
    end
    `CHK("event", e, seen)
  endtask
  // expected {oe, out} of a pin
  function automatic logic [1:0] drv(input logic [3:0] c, input logic s);
    case (c)
      4'h2, 4'h3: return {1'b1, c[0]};
      4'h4, 4'h5: return {1'b1, s ^ c[0]};
      4'h6: return {!s, 1'b0};
      4'h7: return {s, 1'b0};
      default: return 2'b00;
    endcase
  endfunction
  ////////////////////////////////////////
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) rd(i < 2 ? 8'(8'h0e + i) : 8'(8'h10 + i), 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'(8'h12 + i), 8'(8'h21 + i));
    rd(8'h14, 8'h23);
    $display("test registers done");
    for (int c = 0; c < 16; c++)
      for (int s = 0; s < 2; s++)
      begin
        for (int i = 0; i < 4; i++) st[8'h21 + i] <= 1'(s);
        wr(8'h0e, {4'(c), 4'(c)});
        wr(8'h0f, {4'(c), 4'(c)});
        repeat (5) @(posedge core_clk);
        d = drv(4'(c), 1'(s));
        `CHK("oe", {4{d[1]}}, pin_oe)
        `CHK("out", {4{d[0]}}, pin_out)
        `CHK("sense", {4{(d[1] & d[0]) ^ (c == 1)}}, pin_sense)
      end
    $display("test codes done");
    st <= '1;
    wr(8'h12, 8'h70);
    wr(8'h13, 8'h48);
    wr(8'h14, 8'h50);
    wr(8'h15, 8'h30);
    wr(8'h0e, 8'h44);
    wr(8'h0f, 8'h44);
    repeat (2) @(posedge core_clk);
    `CHK("oe", 4'hf, pin_oe)
    `CHK("out", 4'h0, pin_out)
    $display("test blocked done");
    st <= '0;
    wr(8'h0e, 8'h10);
    wr(8'h0f, 8'h00);
    repeat (5) @(posedge core_clk);
    ev(4'hf, 4'b1101);
    `CHK("sense", 4'b1101, pin_sense)
    rd(8'h4e, 8'h0f);
    ev(4'h0, 4'b0010);
    wr(8'h0e, 8'h01);
    repeat (2) @(posedge core_clk);
    ev(4'hf, 4'b1110);
    `CHK("sense", 4'b1110, pin_sense)
    ev(4'h0, 4'b0001);
    $display("test events done");
    wr(8'h0e, 8'h33);
    chan_rst <= 1'b1;
    wr(8'h0f, 8'h33);
    chan_rst <= 1'b0;
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    `CHK("oe", 4'h0, pin_oe)
    $display("test channel reset done");
    close_out();
  end
endmodule
